// [verilog/cpsm_pkg.sv]
// Purpose: shared constants and types for the core power and status mode controller
// Assumes: one clock, aclk at 10 MHz
// Notes: register offsets and field positions are named once here
package cpsm_pkg;

  localparam int CPSM_AW = 4;
  localparam logic [CPSM_AW-1:0] CPSM_OFF_STATUS = 4'h0;
  localparam logic [CPSM_AW-1:0] CPSM_OFF_CONFIG = 4'h4;
  localparam logic [CPSM_AW-1:0] CPSM_OFF_PMODE = 4'h8;
  localparam logic [CPSM_AW-1:0] CPSM_OFF_PARITY = 4'hC;

  // status word field positions
  localparam int CPSM_B_IRQ_EN = 0;
  localparam int CPSM_B_USER_WIDE = 1;
  localparam int CPSM_B_SUP_WIDE = 2;
  localparam int CPSM_B_KERN_WIDE = 3;
  localparam int CPSM_B_SWAP = 4;
  localparam int CPSM_B_PEXC_INH = 5;
  localparam int CPSM_B_PAR_OVR = 6;
  localparam int CPSM_B_BOOT_VEC = 7;
  localparam int CPSM_STATUS_W = 8;
  localparam logic [CPSM_STATUS_W-1:0] CPSM_STATUS_RST = 8'h80;
  localparam int CPSM_CONFIG_W = 8;
  localparam logic [CPSM_CONFIG_W-1:0] CPSM_CONFIG_RST = 8'h00;
  localparam int CPSM_PAR_W = 8;

  localparam logic [63:0] CPSM_VEC_TLB_BOOT = 64'hFFFFFFFFBFC00200;
  localparam logic [63:0] CPSM_VEC_GEN_BOOT = 64'hFFFFFFFFBFC00380;
  localparam logic [63:0] CPSM_VEC_TLB_NORM = 64'hFFFFFFFF80000000;
  localparam logic [63:0] CPSM_VEC_GEN_NORM = 64'hFFFFFFFF80000180;

  localparam logic [1:0] CPSM_RESP_OKAY = 2'h0;
  localparam logic [1:0] CPSM_RESP_SLVERR = 2'h2;

  typedef enum logic [3:0] {
    CPSM_FULL = 4'h1,
    CPSM_STANDBY = 4'h2,
    CPSM_SUSPEND = 4'h4,
    CPSM_HIBERNATE = 4'h8
  } cpsm_mode_type;

  // low-power entry request from the pipeline
  typedef enum logic [1:0] {
    CPSM_REQ_STANDBY = 2'h0,
    CPSM_REQ_SUSPEND = 2'h1,
    CPSM_REQ_HIBERNATE = 2'h2
  } cpsm_req_type;

  typedef struct packed {
    logic power_pin;
    logic wake_timer;
    logic card_detect_pin;
    logic gpio3;
  } cpsm_wake_type;

  typedef struct packed {
    logic core_clk_en;
    logic periph_clk_en;
    logic bus_clk_en;
    logic pipe_halt;
    logic dram_self_refresh;
  } cpsm_gate_type;

endpackage

// [verilog/cpsm_mode_fsm.sv]
// Purpose: power mode state machine with clock gate enables
// Assumes: retire pulse from write-back, bus idle level, wake events synchronous
// Notes: gated clocks park high; enables here drive the clock gating cells
`timescale 1ns/1ps
`default_nettype none
module cpsm_mode_fsm
  import cpsm_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic retire_valid,
  input var cpsm_req_type retire_req,
  input wire logic bus_idle,
  input wire logic irq_any,
  input var cpsm_wake_type wake,
  output var cpsm_mode_type mode,
  output var cpsm_gate_type gate,
  output logic entry_pending
);

  typedef enum logic [3:0] {
    CPSM_P_NONE = 4'h1,
    CPSM_P_STBY = 4'h2,
    CPSM_P_SUSP = 4'h4,
    CPSM_P_HIB = 4'h8
  } cpsm_pend_type;

  cpsm_mode_type mode_r, mode_nxt;
  cpsm_pend_type pend_r, pend_nxt;
  logic sr_r, sr_nxt;
  wire logic hib_wake = wake.power_pin | wake.wake_timer | wake.card_detect_pin | wake.gpio3;
  wire logic accept = (mode_r == CPSM_FULL) && (pend_r == CPSM_P_NONE) && retire_valid;

  always_comb begin
    mode_nxt = mode_r;
    pend_nxt = pend_r;
    sr_nxt = sr_r;
    unique case (mode_r)
      CPSM_FULL: begin
        sr_nxt = 1'b0;
        if (accept) begin
          unique case (retire_req)
            CPSM_REQ_STANDBY: pend_nxt = CPSM_P_STBY;
            CPSM_REQ_SUSPEND: begin
              pend_nxt = CPSM_P_SUSP;
              sr_nxt = 1'b1; // self refresh first, then wait for idle
            end
            default: pend_nxt = CPSM_P_HIB;
          endcase
        end else if (pend_r == CPSM_P_SUSP) begin
          sr_nxt = 1'b1;
          if (bus_idle && sr_r) begin
            mode_nxt = CPSM_SUSPEND;
            pend_nxt = CPSM_P_NONE;
          end
        end else if (pend_r == CPSM_P_STBY && bus_idle) begin
          mode_nxt = CPSM_STANDBY;
          pend_nxt = CPSM_P_NONE;
        end else if (pend_r == CPSM_P_HIB && bus_idle) begin
          mode_nxt = CPSM_HIBERNATE;
          pend_nxt = CPSM_P_NONE;
          sr_nxt = 1'b1;
        end
      end
      CPSM_STANDBY: if (irq_any) mode_nxt = CPSM_FULL;
      CPSM_SUSPEND: if (irq_any) begin
        mode_nxt = CPSM_FULL;
        sr_nxt = 1'b0;
      end
      CPSM_HIBERNATE: if (hib_wake) begin
        mode_nxt = CPSM_FULL;
        sr_nxt = 1'b0;
      end
      default: begin
        mode_nxt = CPSM_FULL;
        pend_nxt = CPSM_P_NONE;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode_r <= CPSM_FULL;
      pend_r <= CPSM_P_NONE;
      sr_r <= 1'b0;
    end else begin
      mode_r <= mode_nxt;
      pend_r <= pend_nxt;
      sr_r <= sr_nxt;
    end
  end

  // registers and caches hold value because only clocks stop, never a reset
  assign mode = mode_r;
  assign entry_pending = (pend_r != CPSM_P_NONE);
  assign gate.core_clk_en = (mode_r == CPSM_FULL);
  assign gate.pipe_halt = (mode_r != CPSM_FULL);
  assign gate.periph_clk_en = (mode_r == CPSM_FULL) || (mode_r == CPSM_STANDBY);
  assign gate.bus_clk_en = (mode_r != CPSM_HIBERNATE);
  assign gate.dram_self_refresh = sr_r;

endmodule // cpsm_mode_fsm
`default_nettype wire

// [verilog/cpsm_top.sv]
// Purpose: core power mode and status word mode bit controller
// Assumes: AXI4-Lite slave on aclk, all inputs synchronous to aclk
// Notes: one write and one read at a time; unmapped offsets answer SLVERR
`timescale 1ns/1ps
`default_nettype none
module cpsm_top
  import cpsm_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [CPSM_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [CPSM_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic retire_valid,
  input var cpsm_req_type retire_req,
  input wire logic bus_idle,
  input wire logic [7:0] irq_lines,
  input wire logic nmi,
  input var cpsm_wake_type wake,
  input wire logic [1:0] priv_mode,
  input wire logic tlb_miss,
  input wire logic [CPSM_PAR_W-1:0] parity_calc,
  input wire logic cache_fill,
  input wire logic parity_err,
  output var cpsm_mode_type power_mode,
  output var cpsm_gate_type clk_gate,
  output logic irq_taken,
  output logic parity_exc,
  output logic [CPSM_PAR_W-1:0] dcache_parity,
  output logic [CPSM_PAR_W-1:0] icache_parity,
  output logic allow_64bit,
  output logic use_ext_miss,
  output logic [63:0] tlb_miss_vec,
  output logic [63:0] gen_exc_vec,
  output logic big_endian
);

  ////////////////////////////////////////////////////////////////////////////
  // status, config and parity value registers

  logic [CPSM_STATUS_W-1:0] status_r;
  logic [CPSM_CONFIG_W-1:0] config_r;
  logic [CPSM_PAR_W-1:0] parity_value_reg_r;
  logic aw_held_r, w_held_r, bvalid_r, rvalid_r;
  logic [CPSM_AW-1:0] awaddr_r;
  logic [31:0] wdata_r, rdata_r;
  logic [3:0] wstrb_r;
  logic [1:0] bresp_r, rresp_r;

  function automatic logic map_hit(input logic [CPSM_AW-1:0] a);
    map_hit = (a == CPSM_OFF_STATUS) || (a == CPSM_OFF_CONFIG) ||
              (a == CPSM_OFF_PMODE) || (a == CPSM_OFF_PARITY);
  endfunction

  // write channel: address and data taken in either order, held until both
  wire logic aw_fire = s_axi_awvalid && s_axi_awready;
  wire logic w_fire = s_axi_wvalid && s_axi_wready;
  wire logic aw_have = aw_held_r || aw_fire;
  wire logic w_have = w_held_r || w_fire;
  wire logic wr_do = aw_have && w_have && !bvalid_r;
  wire logic [CPSM_AW-1:0] wr_addr = aw_held_r ? awaddr_r : s_axi_awaddr;
  wire logic [31:0] wr_data = w_held_r ? wdata_r : s_axi_wdata;
  wire logic [3:0] wr_strb = w_held_r ? wstrb_r : s_axi_wstrb;
  wire logic wr_stat = wr_do && wr_addr == CPSM_OFF_STATUS && wr_strb[0];
  wire logic wr_cfg = wr_do && wr_addr == CPSM_OFF_CONFIG && wr_strb[0];
  wire logic wr_par = wr_do && wr_addr == CPSM_OFF_PARITY && wr_strb[0];

  assign s_axi_awready = !aw_held_r && !bvalid_r;
  assign s_axi_wready = !w_held_r && !bvalid_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;

  // byte order swap is forced to zero: only little endian exists
  wire logic [CPSM_STATUS_W-1:0] stat_wr_val =
    wr_data[CPSM_STATUS_W-1:0] & ~(CPSM_STATUS_W'(1) << CPSM_B_SWAP);

  logic [CPSM_STATUS_W-1:0] status_nxt;
  always_comb begin
    status_nxt = status_r;
    if (wr_stat) status_nxt = stat_wr_val;
    if (nmi) status_nxt[CPSM_B_BOOT_VEC] = 1'b1; // nmi wins over a same-cycle write
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status_r <= CPSM_STATUS_RST; // boot vector select set on reset
      config_r <= CPSM_CONFIG_RST;
      parity_value_reg_r <= '0;
    end else begin
      status_r <= status_nxt;
      if (wr_cfg) config_r <= wr_data[CPSM_CONFIG_W-1:0];
      if (wr_par) parity_value_reg_r <= wr_data[CPSM_PAR_W-1:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r <= CPSM_RESP_OKAY;
      awaddr_r <= '0;
      wdata_r <= '0;
      wstrb_r <= '0;
    end else begin
      if (aw_fire) awaddr_r <= s_axi_awaddr;
      if (w_fire) begin
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end
      aw_held_r <= wr_do ? 1'b0 : aw_have;
      w_held_r <= wr_do ? 1'b0 : w_have;
      if (wr_do) begin
        bvalid_r <= 1'b1;
        bresp_r <= map_hit(wr_addr) ? CPSM_RESP_OKAY : CPSM_RESP_SLVERR;
      end else if (s_axi_bready) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read channel: one cycle after address, data held until rready

  wire logic ar_fire = s_axi_arvalid && s_axi_arready;
  assign s_axi_arready = !rvalid_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;

  wire logic [31:0] rd_mux =
    (s_axi_araddr == CPSM_OFF_STATUS) ? 32'(status_r) :
    (s_axi_araddr == CPSM_OFF_CONFIG) ? 32'(config_r) :
    (s_axi_araddr == CPSM_OFF_PMODE) ? 32'(power_mode) :
    (s_axi_araddr == CPSM_OFF_PARITY) ? 32'(parity_value_reg_r) : 32'h00000000;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_r <= 1'b0;
      rdata_r <= '0;
      rresp_r <= CPSM_RESP_OKAY;
    end else if (ar_fire) begin
      rvalid_r <= 1'b1;
      rdata_r <= rd_mux;
      rresp_r <= map_hit(s_axi_araddr) ? CPSM_RESP_OKAY : CPSM_RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // mode bit decode, combinational so a write takes effect next cycle

  wire logic kern_wide = status_r[CPSM_B_KERN_WIDE];
  wire logic sup_wide = status_r[CPSM_B_SUP_WIDE];
  wire logic user_wide = status_r[CPSM_B_USER_WIDE];
  wire logic boot_vec = status_r[CPSM_B_BOOT_VEC];
  wire logic is_kern = (priv_mode == 2'h0);
  wire logic is_sup = (priv_mode == 2'h1);
  wire logic is_user = (priv_mode == 2'h2);

  assign allow_64bit = is_kern || (is_sup && sup_wide) ||
    (is_user && user_wide);
  assign use_ext_miss = tlb_miss && ((is_kern && kern_wide) ||
    (is_sup && sup_wide) || (is_user && user_wide));
  assign tlb_miss_vec = boot_vec ? CPSM_VEC_TLB_BOOT : CPSM_VEC_TLB_NORM;
  assign gen_exc_vec = boot_vec ? CPSM_VEC_GEN_BOOT : CPSM_VEC_GEN_NORM;
  assign big_endian = status_r[CPSM_B_SWAP];

  // override keeps test code able to plant bad parity on purpose
  assign dcache_parity = status_r[CPSM_B_PAR_OVR] ? parity_value_reg_r : parity_calc;
  assign icache_parity = (status_r[CPSM_B_PAR_OVR] && cache_fill) ?
    parity_value_reg_r : parity_calc;
  assign parity_exc = parity_err && !status_r[CPSM_B_PEXC_INH];
  wire logic irq_any = |irq_lines;
  assign irq_taken = (irq_any && status_r[CPSM_B_IRQ_EN]) || nmi;

  ////////////////////////////////////////////////////////////////////////////
  // power mode machine; wake uses raw interrupt lines, not the enable

  cpsm_mode_fsm u_fsm (
    .aclk(aclk),
    .aresetn(aresetn),
    .retire_valid(retire_valid),
    .retire_req(retire_req),
    .bus_idle(bus_idle),
    .irq_any(irq_any || nmi),
    .wake(wake),
    .mode(power_mode),
    .gate(clk_gate),
    .entry_pending()
  );

endmodule // cpsm_top
`default_nettype wire

// [bench/cpsm_pipe_model.sv]
// Purpose: pipeline and system bus stand-in for cpsm_top
// Assumes: go is a one-cycle strobe from the bench
// Notes: busy sets how long the bus stays busy after a retire
`timescale 1ns/1ps
`default_nettype none
module cpsm_pipe_model
  import cpsm_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic go,
  input var cpsm_req_type req,
  input wire logic [3:0] busy,
  output logic retire_valid,
  output var cpsm_req_type retire_req,
  output logic bus_idle
);
  logic [3:0] cnt_r;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_r <= 4'h0;
      retire_valid <= 1'h0;
      retire_req <= CPSM_REQ_STANDBY;
    end else begin
      retire_valid <= go;
      retire_req <= go ? req : retire_req;
      cnt_r <= go ? busy : cnt_r - {3'h0, cnt_r != 4'h0};
    end
  end
  // bus stays busy a while so the entry has to wait for idle
  assign bus_idle = (cnt_r == 4'h0);
endmodule // cpsm_pipe_model
`default_nettype wire

// [bench/cpsm_top_chk.sv]
// Purpose: port assertions for cpsm_top
// Assumes: one clock, sync active-low reset
// Notes: bound from the bench top file
`timescale 1ns/1ps
`default_nettype none
module cpsm_top_chk
  import cpsm_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] irq_lines,
  input wire logic nmi,
  input var cpsm_wake_type wake,
  input wire logic [1:0] priv_mode,
  input wire logic parity_err,
  input var cpsm_mode_type power_mode,
  input var cpsm_gate_type clk_gate,
  input wire logic parity_exc,
  input wire logic allow_64bit,
  input wire logic [63:0] gen_exc_vec,
  input wire logic big_endian
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  wire irq_any = (|irq_lines) || nmi;
  wire low = power_mode inside {CPSM_STANDBY, CPSM_SUSPEND};
  AST_RST_FULL: assert property ($rose(aresetn) |-> power_mode == CPSM_FULL)
    else $error("mode not full after reset");
  AST_ONE_MODE: assert property ($onehot(power_mode))
    else $error("power mode not one-hot");
  AST_LOW_WAKE: assert property (low && irq_any |=> power_mode == CPSM_FULL)
    else $error("no wake on interrupt");
  AST_LOW_HOLD: assert property (low && !irq_any |=> $stable(power_mode))
    else $error("low power mode left without interrupt");
  AST_HIB_WAKE: assert property (
    power_mode == CPSM_HIBERNATE && (|wake) |=> power_mode == CPSM_FULL)
    else $error("no wake from hibernate");
  AST_HIB_HOLD: assert property (
    power_mode == CPSM_HIBERNATE && !(|wake) |=> power_mode == CPSM_HIBERNATE)
    else $error("hibernate left without wake");
  AST_STBY_GATE: assert property (power_mode == CPSM_STANDBY |-> clk_gate[4:1] == 4'h7)
    else $error("standby gates wrong");
  AST_SUSP_GATE: assert property (power_mode == CPSM_SUSPEND |-> clk_gate == 5'h07)
    else $error("suspend gates wrong");
  AST_HIB_GATE: assert property (power_mode == CPSM_HIBERNATE |-> clk_gate[4:2] == 3'h0)
    else $error("hibernate clocks running");
  AST_NMI_BOOT: assert property (nmi |=> gen_exc_vec == CPSM_VEC_GEN_BOOT)
    else $error("nmi left boot vector off");
  AST_ENDIAN: assert property (!big_endian)
    else $error("big endian seen");
  AST_KERN_64: assert property (priv_mode == 2'h0 |-> allow_64bit)
    else $error("kernel 64-bit refused");
  AST_PAR_EXC: assert property (parity_exc |-> parity_err)
    else $error("parity exception without error");
endmodule // cpsm_top_chk
`default_nettype wire

// [bench/core_power_and_status_modes_test.sv]
// Purpose: self-checking bench for cpsm_top
// Assumes: AXI4-Lite master tasks, pipeline model on the far side
// Notes: bready and rready stay high, which the bus allows
`timescale 1ns/1ps
`default_nettype none
module core_power_and_status_modes_test
  import cpsm_pkg::*;
;
  logic aclk = 1'h0, aresetn = 1'h0, awvalid = 1'h0, wvalid = 1'h0, arvalid = 1'h0;
  logic go = 1'h0, nmi = 1'h0, tlb_miss = 1'h1, fill = 1'h1, parity_value_reg = 1'h1;
  logic [3:0] awaddr = 4'h0, araddr = 4'h0, wstrb = 4'hF;
  logic [31:0] wdata = 32'h0, rdata, rd;
  logic [7:0] irq_lines = 8'h00, dpar, ipar;
  logic [1:0] priv_mode = 2'h0, bresp, rresp, rr, br;
  cpsm_req_type go_req = CPSM_REQ_STANDBY, retire_req;
  cpsm_wake_type wake = 4'h0;
  cpsm_mode_type power_mode;
  cpsm_gate_type clk_gate;
  logic awready, wready, bvalid, arready, rvalid, retire_valid, bus_idle;
  logic irq_taken, parity_exc, w64, ext, big_endian;
  logic [63:0] tvec, gvec;
  int n_fail = 0, checked = 0, cyc = 0;
  always #50 aclk = ~aclk;
  cpsm_pipe_model i_pipe (.aclk(aclk), .aresetn(aresetn), .go(go), .req(go_req),
    .busy(4'h6), .retire_valid(retire_valid), .retire_req(retire_req), .bus_idle(bus_idle));
  cpsm_top i_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(1'h1), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(1'h1),
    .retire_valid(retire_valid), .retire_req(retire_req), .bus_idle(bus_idle),
    .irq_lines(irq_lines), .nmi(nmi), .wake(wake), .priv_mode(priv_mode),
    .tlb_miss(tlb_miss), .parity_calc(8'h3C), .cache_fill(fill), .parity_err(parity_value_reg),
    .power_mode(power_mode), .clk_gate(clk_gate), .irq_taken(irq_taken),
    .parity_exc(parity_exc), .dcache_parity(dpar), .icache_parity(ipar),
    .allow_64bit(w64), .use_ext_miss(ext), .tlb_miss_vec(tvec), .gen_exc_vec(gvec),
    .big_endian(big_endian));
  ////////////////////////////////////////
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
    checked++;
    if (g !== e) begin
      n_fail++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge aclk);
  endtask
  task automatic reset_dut();
    aresetn <= 1'h0;
    tick(8);
    aresetn <= 1'h1;
    tick(1);
  endtask
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    do begin
      tick(1);
      if (awvalid && awready) awvalid <= 1'h0;
      if (wvalid && wready) wvalid <= 1'h0;
    end while (bvalid !== 1'h1);
    br = bresp;
  endtask
  task automatic axi_rd(input logic [3:0] a);
    araddr <= a;
    arvalid <= 1'h1;
    do begin
      tick(1);
      if (arvalid && arready) arvalid <= 1'h0;
    end while (rvalid !== 1'h1);
    rd = rdata;
    rr = rresp;
  endtask
  task automatic rdchk(input logic [3:0] a, input logic [31:0] e);
    axi_rd(a);
    chk("rdata", e, rd);
    chk("rresp", CPSM_RESP_OKAY, rr);
  endtask
  task automatic wait_mode(input cpsm_mode_type m);
    for (int n = 0; n < 40 && power_mode !== m; n++) tick(1);
    chk("mode", m, power_mode);
  endtask
  task automatic enter(input cpsm_req_type q, input cpsm_mode_type m);
    go_req <= q;
    go <= 1'h1;
    tick(1);
    go <= 1'h0;
    tick(3);
    chk("early", CPSM_FULL, power_mode);
    if (q == CPSM_REQ_SUSPEND) chk("refresh", 1'h1, clk_gate.dram_self_refresh);
    wait_mode(m);
  endtask
  ////////////////////////////////////////
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 3000) begin
      n_fail++;
      end_of_test();
    end
  end
  initial begin
    reset_dut();
    rdchk(CPSM_OFF_STATUS, 32'h80);
    rdchk(CPSM_OFF_PMODE, 32'h01);
    chk("gvec", CPSM_VEC_GEN_BOOT, gvec);
    chk("tvec", CPSM_VEC_TLB_BOOT, tvec);
    axi_rd(4'h2);
    chk("unmapped", CPSM_RESP_SLVERR, rr);
    chk("unmapped_data", 32'h0, rd);
    axi_wr(4'h2, 32'hFF);
    chk("unmapped_wr", CPSM_RESP_SLVERR, br);
    rdchk(CPSM_OFF_CONFIG, 32'h00);
    axi_wr(CPSM_OFF_CONFIG, 32'h5A);
    chk("bresp", CPSM_RESP_OKAY, br);
    rdchk(CPSM_OFF_CONFIG, 32'h5A);
    axi_wr(CPSM_OFF_STATUS, 32'h11);
    rdchk(CPSM_OFF_STATUS, 32'h01);
    chk("gvec", CPSM_VEC_GEN_NORM, gvec);
    chk("tvec", CPSM_VEC_TLB_NORM, tvec);
    for (int s = 0; s < 2; s++) begin
      axi_wr(CPSM_OFF_STATUS, s ? 32'h0F : 32'h01);
      for (int p = 0; p < 3; p++) begin
        priv_mode <= 2'(p);
        tick(1);
        chk("wide64", p == 0 || s == 1, w64);
        chk("ext_miss", s, ext);
      end
    end
    tlb_miss <= 1'h0;
    tick(1);
    chk("no_miss", 1'h0, ext);
    tlb_miss <= 1'h1;
    irq_lines <= 8'h80;
    tick(1);
    chk("irq_on", 1'h1, irq_taken);
    axi_wr(CPSM_OFF_STATUS, 32'h0E);
    chk("irq_off", 1'h0, irq_taken);
    irq_lines <= 8'h00;
    $display("test status bits done");
    axi_wr(CPSM_OFF_PARITY, 32'hA5);
    wstrb <= 4'hE;
    axi_wr(CPSM_OFF_PARITY, 32'h5A);
    wstrb <= 4'hF;
    rdchk(CPSM_OFF_PARITY, 32'hA5);
    axi_wr(CPSM_OFF_STATUS, 32'h40);
    chk("dpar", 8'hA5, dpar);
    chk("ipar", 8'hA5, ipar);
    chk("pexc", 1'h1, parity_exc);
    fill <= 1'h0;
    tick(1);
    chk("ipar_nofill", 8'h3C, ipar);
    fill <= 1'h1;
    axi_wr(CPSM_OFF_STATUS, 32'h20);
    chk("dpar", 8'h3C, dpar);
    chk("pexc", 1'h0, parity_exc);
    nmi <= 1'h1;
    tick(1);
    chk("irq_nmi", 1'h1, irq_taken);
    nmi <= 1'h0;
    tick(1);
    rdchk(CPSM_OFF_STATUS, 32'hA0);
    $display("test parity and nmi done");
    axi_wr(CPSM_OFF_STATUS, 32'h0E);
    enter(CPSM_REQ_STANDBY, CPSM_STANDBY);
    chk("gate", 4'h7, clk_gate[4:1]);
    go_req <= CPSM_REQ_SUSPEND;
    go <= 1'h1;
    tick(1);
    go <= 1'h0;
    tick(8);
    rdchk(CPSM_OFF_PMODE, 32'h02);
    irq_lines <= 8'h01;
    wait_mode(CPSM_FULL);
    irq_lines <= 8'h00;
    chk("gate", 5'h1C, clk_gate);
    enter(CPSM_REQ_SUSPEND, CPSM_SUSPEND);
    chk("gate", 5'h07, clk_gate);
    tick(10);
    chk("stay", CPSM_SUSPEND, power_mode);
    irq_lines <= 8'h40;
    wait_mode(CPSM_FULL);
    irq_lines <= 8'h00;
    rdchk(CPSM_OFF_STATUS, 32'h0E);
    for (int k = 0; k < 4; k++) begin
      enter(CPSM_REQ_HIBERNATE, CPSM_HIBERNATE);
      chk("gate", 3'h0, clk_gate[4:2]);
      wake <= cpsm_wake_type'(4'h8 >> k);
      wait_mode(CPSM_FULL);
      wake <= cpsm_wake_type'(4'h0);
      tick(1);
    end
    enter(CPSM_REQ_STANDBY, CPSM_STANDBY);
    reset_dut();
    chk("mode", CPSM_FULL, power_mode);
    rdchk(CPSM_OFF_STATUS, 32'h80);
    rdchk(CPSM_OFF_CONFIG, 32'h00);
    $display("test power modes done");
    end_of_test();
  end
endmodule // core_power_and_status_modes_test
bind cpsm_top cpsm_top_chk i_chk (.aclk(aclk), .aresetn(aresetn), .irq_lines(irq_lines),
  .nmi(nmi), .wake(wake), .priv_mode(priv_mode), .parity_err(parity_err),
  .power_mode(power_mode), .clk_gate(clk_gate), .parity_exc(parity_exc),
  .allow_64bit(allow_64bit), .gen_exc_vec(gen_exc_vec), .big_endian(big_endian));
`default_nettype wire
